// ===== rtl/rgs_pkg.sv
// Constants and types for the regulator enable sequencer
// Functional notes
// - Channel on while its enable is high
// - Enables map to converter, regulator A, B
// - Each switch-on starts that channel's soft-start ramp
// - Mode high forces PWM, low automatic PWM/PSM
// - Over 150 C turns all channels off
// - Stay off until below 130 C
// - Leaving thermal shutdown restarts through soft-start
// - Undervoltage shuts channels and converter switches off
// - Supply recovery re-enables channels per enables
// - Option selects higher 3.65 V lockout threshold
// - Watchdog-2 restart follows selected order
// - Two milliseconds between successive activations
// - Order code selects one of four sequences
package rgs_pkg;
   // Register byte addresses
   localparam logic [3:0] RGS_ADDR_CTRL   = 4'h0;
   localparam logic [3:0] RGS_ADDR_STATUS = 4'h4;
   // Control register fields
   localparam int         RGS_CTRL_UVHI_BIT = 0;
   localparam int         RGS_CTRL_ORD_LSB  = 1;
   localparam logic       RGS_UVHI_RESET    = 1'b0;
   localparam logic [1:0] RGS_ORDER_RESET   = 2'h0;
   // Status register fields
   localparam int         RGS_ST_ON_LSB   = 0;
   localparam int         RGS_ST_RAMP_LSB = 3;
   localparam int         RGS_ST_TSD_BIT  = 6;
   localparam int         RGS_ST_UV_BIT   = 7;
   localparam int         RGS_ST_SEQ_BIT  = 8;
   // Restart order codes
   localparam logic [1:0] RGS_ORD_AB_C = 2'h0;
   localparam logic [1:0] RGS_ORD_C_AB = 2'h1;
   localparam logic [1:0] RGS_ORD_A_CB = 2'h2;
   localparam logic [1:0] RGS_ORD_ALL  = 2'h3;
   // Timing
   localparam int RGS_CLK_KHZ      = 125000;
   localparam int RGS_SEQ_DELAY_MS = 2;
   localparam int RGS_SEQ_CYC      = RGS_SEQ_DELAY_MS * RGS_CLK_KHZ;
   localparam int RGS_SOFT_US      = 100;
   localparam int RGS_SOFT_CYC     = (RGS_SOFT_US * RGS_CLK_KHZ + 999) / 1000;
   localparam int RGS_CNT_W        = 20;

   // One bit per regulator channel
   typedef struct packed {
      logic lin_b;
      logic lin_a;
      logic conv;
   } rgs_chan_t;

   typedef enum logic [1:0] {
      RGS_SEQ_IDLE = 2'b00,
      RGS_SEQ_OFF  = 2'b01,
      RGS_SEQ_WAIT1 = 2'b10,
      RGS_SEQ_WAIT2 = 2'b11
   } rgs_seq_t;
endpackage

// ===== rtl/rgs_top.sv
// Regulator enable sequencer with thermal, lockout and restart control
`timescale 1ns/1ps
module rgs_top
   import rgs_pkg::*;
#(
   parameter int SEQ_CYC  = RGS_SEQ_CYC,
   parameter int SOFT_CYC = RGS_SOFT_CYC
)
(
   input  wire logic        clk,                 // 125 MHz clock
   input  wire logic        nrst,                // Async reset, active low
   input  wire logic [3:0]  avs_address,         // Byte address
   input  wire logic        avs_read,            // Read request
   input  wire logic        avs_write,           // Write request
   input  wire logic [31:0] avs_writedata,       // Write data
   input  wire logic [3:0]  avs_byteenable,      // Byte lanes
   output logic [31:0]      avs_readdata,        // Read data
   output logic             avs_waitrequest,     // Stall
   input  wire logic        converter_enable_pin, // Converter enable
   input  wire logic        linear_a_enable_pin, // Regulator A enable
   input  wire logic        linear_b_enable_pin, // Regulator B enable
   input  wire logic        mode_pin,            // High forces PWM
   input  wire logic        temp_above_150,      // Over-temperature comparator
   input  wire logic        temp_below_130,      // Recovery comparator
   input  wire logic        supply_below_std,    // Below standard lockout level
   input  wire logic        supply_below_high,   // Below 3.65 V lockout level
   input  wire logic        wd2_timeout,         // Watchdog-2 power-cycle pulse
   output rgs_chan_t        chan_on,             // Channel switched on
   output rgs_chan_t        ramp_active,         // Soft-start ramping
   output logic             forced_pwm,          // Converter in forced PWM
   output logic             conv_switch_allow    // Converter power switches allowed
);

   logic       rst_meta_q;
   logic       rst_n_q;
   logic       uvhi_q;
   logic [1:0] order_q;
   logic       tsd_q;
   logic       uv_q;
   logic       uv_now;
   rgs_seq_t   seq_q;
   logic [RGS_CNT_W-1:0] seq_cnt_q;
   rgs_chan_t  allow_q;
   rgs_chan_t  pins;
   rgs_chan_t  gate;
   rgs_chan_t  on_q;
   rgs_chan_t  ramp_q;
   logic       pwm_q;
   logic       sw_q;
   logic       wait_q;
   logic [31:0] rdata_q;
   logic       acc_go;
   logic       delay_done;

   // Reset release through two flops
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // Channel position in the restart order, one-hot per step; the all-at-once code sets every channel
   function automatic rgs_chan_t step_mask(input logic [1:0] ord, input logic [1:0] step);
      rgs_chan_t m;
      m = '0;
      case (ord)
         RGS_ORD_AB_C:
         begin
            m.lin_a = (step == 2'h0);
            m.lin_b = (step == 2'h1);
            m.conv  = (step == 2'h2);
         end
         RGS_ORD_C_AB:
         begin
            m.conv  = (step == 2'h0);
            m.lin_a = (step == 2'h1);
            m.lin_b = (step == 2'h2);
         end
         RGS_ORD_A_CB:
         begin
            m.lin_a = (step == 2'h0);
            m.conv  = (step == 2'h1);
            m.lin_b = (step == 2'h2);
         end
         default:
         begin
            m = '1;
         end
      endcase
      return m;
   endfunction

   // Enable pins gathered into one channel word
   always_comb
   begin
      pins.conv  = converter_enable_pin;
      pins.lin_a = linear_a_enable_pin;
      pins.lin_b = linear_b_enable_pin;
   end

   // Lockout comparator chosen by the high-threshold option
   always_comb
   begin
      if (uvhi_q)
      begin
         uv_now = supply_below_high;
      end
      else
      begin
         uv_now = supply_below_std;
      end
   end

   // Protection overrides the pins; the sequencer mask holds back channels
   always_comb
   begin
      if (tsd_q || uv_q)
      begin
         gate = '0;
      end
      else
      begin
         gate = pins & allow_q;
      end
   end

   // Bus access start and restart delay expiry
   assign acc_go     = (avs_read || avs_write) && wait_q;
   assign delay_done = (seq_cnt_q >= RGS_CNT_W'(SEQ_CYC - 1));

   // Thermal shutdown latch with hysteresis, trip wins over recovery
   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         tsd_q <= 1'b0;
      end
      else if (temp_above_150)
      begin
         tsd_q <= 1'b1;
      end
      else if (temp_below_130)
      begin
         tsd_q <= 1'b0;
      end
   end

   // Undervoltage lockout state
   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         uv_q <= 1'b0;
         sw_q <= 1'b0;
      end
      else
      begin
         uv_q <= uv_now;
         sw_q <= !uv_now && on_q.conv && !tsd_q;
      end
   end

   // Watchdog-2 restart sequencer
   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         seq_q     <= RGS_SEQ_IDLE;
         seq_cnt_q <= '0;
         allow_q   <= '1;
      end
      else if (uv_q)
      begin
         seq_q     <= RGS_SEQ_IDLE;
         seq_cnt_q <= '0;
         allow_q   <= '1;
      end
      else if (wd2_timeout)
      begin
         seq_q     <= RGS_SEQ_OFF;
         seq_cnt_q <= '0;
         allow_q   <= '0;
      end
      else
      begin
         case (seq_q)
            RGS_SEQ_IDLE:
            begin
               seq_cnt_q <= '0;
            end
            RGS_SEQ_OFF:
            begin
               allow_q <= step_mask(order_q, 2'h0);
               seq_q   <= (order_q == RGS_ORD_ALL) ? RGS_SEQ_IDLE : RGS_SEQ_WAIT1;
            end
            RGS_SEQ_WAIT1:
            begin
               seq_cnt_q <= delay_done ? '0 : seq_cnt_q + 1'b1;
               if (delay_done)
               begin
                  allow_q <= allow_q | step_mask(order_q, 2'h1);
                  seq_q   <= RGS_SEQ_WAIT2;
               end
            end
            RGS_SEQ_WAIT2:
            begin
               seq_cnt_q <= delay_done ? '0 : seq_cnt_q + 1'b1;
               if (delay_done)
               begin
                  allow_q <= '1;
                  seq_q   <= RGS_SEQ_IDLE;
               end
            end
            default:
            begin
               seq_q <= RGS_SEQ_IDLE;
            end
         endcase
      end
   end

   // Per-channel on state and soft-start ramp
   generate
      for (genvar i = 0; i < 3; i++)
      begin : g_chan
         logic [RGS_CNT_W-1:0] ramp_cnt_q;
         always_ff @(posedge clk or negedge rst_n_q)
         begin
            if (!rst_n_q)
            begin
               on_q[i]    <= 1'b0;
               ramp_q[i]  <= 1'b0;
               ramp_cnt_q <= '0;
            end
            else
            begin
               on_q[i] <= gate[i];
               if (!gate[i])
               begin
                  ramp_q[i]  <= 1'b0;
                  ramp_cnt_q <= '0;
               end
               else if (!on_q[i])
               begin
                  ramp_q[i]  <= 1'b1;
                  ramp_cnt_q <= '0;
               end
               else if (ramp_q[i])
               begin
                  ramp_cnt_q <= ramp_cnt_q + 1'b1;
                  if (ramp_cnt_q >= RGS_CNT_W'(SOFT_CYC - 1))
                  begin
                     ramp_q[i] <= 1'b0;
                  end
               end
            end
         end
      end
   endgenerate

   // Converter mode follows the mode pin
   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         pwm_q <= 1'b0;
      end
      else
      begin
         pwm_q <= mode_pin;
      end
   end

   // Avalon slave: one wait cycle, then the access completes
   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         wait_q  <= 1'b1;
         rdata_q <= '0;
      end
      else
      begin
         wait_q  <= !acc_go;
         rdata_q <= '0;
         if (acc_go && avs_read)
         begin
            case (avs_address)
               RGS_ADDR_CTRL:
               begin
                  rdata_q[RGS_CTRL_UVHI_BIT] <= uvhi_q;
                  rdata_q[RGS_CTRL_ORD_LSB +: 2] <= order_q;
               end
               RGS_ADDR_STATUS:
               begin
                  rdata_q[RGS_ST_ON_LSB +: 3]   <= on_q;
                  rdata_q[RGS_ST_RAMP_LSB +: 3] <= ramp_q;
                  rdata_q[RGS_ST_TSD_BIT]       <= tsd_q;
                  rdata_q[RGS_ST_UV_BIT]        <= uv_q;
                  rdata_q[RGS_ST_SEQ_BIT]       <= (seq_q != RGS_SEQ_IDLE);
               end
               default:
               begin
                  rdata_q <= '0;
               end
            endcase
         end
      end
   end

   // Control register write at the completing edge
   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         uvhi_q  <= RGS_UVHI_RESET;
         order_q <= RGS_ORDER_RESET;
      end
      else if (avs_write && !wait_q && avs_address == RGS_ADDR_CTRL && avs_byteenable[0])
      begin
         uvhi_q  <= avs_writedata[RGS_CTRL_UVHI_BIT];
         order_q <= avs_writedata[RGS_CTRL_ORD_LSB +: 2];
      end
   end

   // Outputs come straight from their registers
   assign chan_on           = on_q;
   assign ramp_active       = ramp_q;
   assign forced_pwm        = pwm_q;
   assign conv_switch_allow = sw_q;
   assign avs_waitrequest   = wait_q;
   assign avs_readdata      = rdata_q;

endmodule

// ===== sim/rgs_proc_model.sv
// Processor-side model driving the enable and mode pins
`timescale 1ns/1ps
module rgs_proc_model
   import rgs_pkg::*;
(
   input  wire logic clk,             // Clock
   input  rgs_chan_t en_req,          // Wanted enables
   input  wire logic mode_req,        // Wanted mode
   output rgs_chan_t en_pins = '0,    // Enable pins
   output logic      mode_pin = 1'b0  // Mode pin
);
   // Port write lands one cycle after firmware asks
   always @(posedge clk)
   begin
      en_pins <= en_req;
      mode_pin <= mode_req;
   end
endmodule

// ===== sim/rgs_top_sva.sv
// Port assertions for the regulator enable sequencer
`timescale 1ns/1ps
module rgs_top_sva
   import rgs_pkg::*;
(
   input wire logic clk,                  // Clock
   input wire logic nrst,                 // Reset, active low
   input wire logic converter_enable_pin, // Pin
   input wire logic linear_b_enable_pin,  // Pin
   input wire logic mode_pin,             // Pin
   input wire logic temp_above_150,       // Hot flag
   input wire logic temp_below_130,       // Cool flag
   input wire logic supply_below_std,     // Low supply
   input wire logic wd2_timeout,          // Watchdog pulse
   input rgs_chan_t chan_on,              // Channels on
   input rgs_chan_t ramp_active,          // Ramps
   input wire logic forced_pwm,           // Mode out
   input wire logic conv_switch_allow     // Switch allow
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Pin to channel gating, soft-start and mode follow
   chk_conv_gate: assert property (!converter_enable_pin |=> !chan_on.conv)
      else $error("conv on, pin low");
   chk_linb_gate: assert property (!linear_b_enable_pin |=> !chan_on.lin_b)
      else $error("lin_b on, pin low");
   chk_ramp_start: assert property ($rose(chan_on.lin_a) |-> ramp_active.lin_a)
      else $error("no ramp");
   chk_mode_follow: assert property ($changed(mode_pin) |=> forced_pwm == $past(mode_pin))
      else $error("mode lag");
   // Protection shutdowns
   chk_therm_off: assert property (temp_above_150 |-> ##2 chan_on == '0)
      else $error("hot, still on");
   chk_therm_hold: assert property (temp_above_150 ##1 !temp_below_130 |=> chan_on == '0)
      else $error("left shutdown early");
   chk_uv_switch: assert property (supply_below_std [*3] |-> !conv_switch_allow && chan_on == '0)
      else $error("lockout ignored");
   chk_wd_off: assert property (wd2_timeout |-> ##2 chan_on == '0)
      else $error("watchdog, still on");
   cover property (wd2_timeout);
   cover property ($rose(chan_on.lin_b));
   cover property (temp_above_150 ##1 temp_below_130);
endmodule

bind rgs_top rgs_top_sva u_sva (.clk(clk), .nrst(nrst),
   .converter_enable_pin(converter_enable_pin), .linear_b_enable_pin(linear_b_enable_pin),
   .mode_pin(mode_pin), .temp_above_150(temp_above_150), .temp_below_130(temp_below_130),
   .supply_below_std(supply_below_std), .wd2_timeout(wd2_timeout), .chan_on(chan_on),
   .ramp_active(ramp_active), .forced_pwm(forced_pwm), .conv_switch_allow(conv_switch_allow));

// ===== sim/rgs_top_tb.sv
// Self-checking bench for the regulator enable sequencer
`timescale 1ns/1ps
module rgs_top_tb
   import rgs_pkg::*;
;
   localparam int SEQ = 20;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic        wreq;
   rgs_chan_t   en_req = '0;
   logic        mode_req = 1'b0;
   rgs_chan_t   pins;
   logic        mode_pin;
   logic        t150 = 1'b0;
   logic        t130 = 1'b1;
   logic        uv_s = 1'b0;
   logic        uv_h = 1'b0;
   logic        wd2 = 1'b0;
   rgs_chan_t   chan_on;
   rgs_chan_t   ramp;
   logic        pwm;
   logic        sw;
   int          failures = 0;
   int          checks_done = 0;

   rgs_proc_model u_proc (.clk(clk), .en_req(en_req), .mode_req(mode_req), .en_pins(pins),
      .mode_pin(mode_pin));
   rgs_top #(.SEQ_CYC(SEQ), .SOFT_CYC(8)) dut (.clk(clk), .nrst(nrst), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hF),
      .avs_readdata(rdat), .avs_waitrequest(wreq), .converter_enable_pin(pins.conv),
      .linear_a_enable_pin(pins.lin_a), .linear_b_enable_pin(pins.lin_b),
      .mode_pin(mode_pin), .temp_above_150(t150), .temp_below_130(t130),
      .supply_below_std(uv_s), .supply_below_high(uv_h), .wd2_timeout(wd2),
      .chan_on(chan_on), .ramp_active(ramp), .forced_pwm(pwm), .conv_switch_allow(sw));

   // Clock
   initial
   begin
      forever #4 clk = ~clk;
   end

   task automatic conclude();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         $display("Error at %0t got %h exp %h", $time, got, exp);
         failures++;
      end
   endtask

   // One bus access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wreq !== 1'b0 && n < 20);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      chk(32'(wreq), 32'h0);
      if (wreq !== 1'b0)
         conclude();
   endtask

   task automatic wait_on(input rgs_chan_t e);
      int n;
      n = 0;
      while (chan_on !== e && n < 40)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(32'(chan_on), 32'(e));
      if (chan_on !== e)
         conclude();
   endtask

   task automatic set_en(input rgs_chan_t e);
      @(posedge clk);
      en_req <= e;
      wait_on(e);
   endtask

   task automatic t_pins();
      rgs_chan_t pat [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
      foreach (pat[i])
      begin
         set_en('0);
         set_en(pat[i]);
         chk(32'(ramp), 32'(pat[i]));
      end
      for (int m = 1; m >= 0; m--)
      begin
         @(posedge clk);
         mode_req <= m[0];
         repeat (3) @(posedge clk);
         #1;
         chk(32'(pwm), 32'(m[0]));
      end
      $display("pins test done");
   endtask

   task automatic t_therm();
      @(posedge clk);
      t150 <= 1'b1;
      t130 <= 1'b0;
      @(posedge clk);
      t150 <= 1'b0;
      wait_on('0);
      repeat (10) @(posedge clk);
      #1;
      chk(32'(chan_on), 32'h0);
      @(posedge clk);
      t130 <= 1'b1;
      wait_on(3'h7);
      chk(32'(ramp), 32'h7);
      $display("thermal test done");
   endtask

   task automatic t_uv();
      logic [31:0] q;
      @(posedge clk);
      uv_s <= 1'b1;
      uv_h <= 1'b1;
      wait_on('0);
      chk(32'(sw), 32'h0);
      bus(1'b0, RGS_ADDR_STATUS, 32'h0, q);
      chk(32'(q[RGS_ST_UV_BIT]), 32'h1);
      @(posedge clk);
      uv_s <= 1'b0;
      wait_on(3'h7);
      @(posedge clk);
      #1;
      chk(32'(sw), 32'h1);
      bus(1'b1, RGS_ADDR_CTRL, 32'h1, q);
      wait_on('0);
      bus(1'b0, 4'hC, 32'h0, q);
      chk(q, 32'h0);
      bus(1'b1, RGS_ADDR_CTRL, 32'h0, q);
      @(posedge clk);
      uv_h <= 1'b0;
      wait_on(3'h7);
      $display("lockout test done");
   endtask

   task automatic t_seq();
      int rank [4][3] = '{'{2, 0, 1}, '{0, 1, 2}, '{1, 0, 2}, '{0, 0, 0}};
      int tr [3];
      int base;
      logic [31:0] q;
      rgs_chan_t prev;
      rgs_chan_t en;
      for (int c = 0; c < 4; c++)
      begin
         en = (c == 3) ? 3'h3 : 3'h7;
         bus(1'b1, RGS_ADDR_CTRL, 32'(c) << 1, q);
         set_en(en);
         @(posedge clk);
         wd2 <= 1'b1;
         tr = '{-1, -1, -1};
         prev = '1;
         for (int n = 0; n < 4 * SEQ; n++)
         begin
            @(posedge clk);
            wd2 <= 1'b0;
            #1;
            for (int k = 0; k < 3; k++)
               if (chan_on[k] && !prev[k])
                  tr[k] = n;
            prev = chan_on;
         end
         base = (c == 1 || c == 3) ? tr[0] : tr[1];
         for (int k = 0; k < 3; k++)
            if (en[k])
               chk(tr[k] - base, rank[c][k] * SEQ);
         chk(32'(base), 32'h2);
         chk(32'(chan_on), 32'(en));
      end
      // Lockout in mid-sequence aborts it and frees every enabled channel
      bus(1'b1, RGS_ADDR_CTRL, 32'h0, q);
      set_en(3'h7);
      @(posedge clk);
      wd2 <= 1'b1;
      @(posedge clk);
      wd2 <= 1'b0;
      repeat (5) @(posedge clk);
      uv_s <= 1'b1;
      uv_h <= 1'b1;
      wait_on('0);
      @(posedge clk);
      uv_s <= 1'b0;
      uv_h <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk(32'(chan_on), 32'h7);
      $display("restart test done");
   endtask

   // Reset, then the scenarios
   initial
   begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      t_pins();
      t_therm();
      t_uv();
      t_seq();
      conclude();
   end
endmodule
